// ### verilog/sltr_defs.svh
//------------------------------------------------------------------
//------------------------------------------------------------------
`ifndef SLTR_DEFS_SVH
`define SLTR_DEFS_SVH

// Transmit register bit positions
`define SLTR_TX_RUN        0
`define SLTR_TX_CTL1       1
`define SLTR_TX_ERROR_IRQ_ENABLE     3
`define SLTR_TRANSMIT_COMPLETE_IRQ_ENABLE    5
`define SLTR_TX_SDONE      6
`define SLTR_TX_PDONE      7
`define SLTR_TX_MODEM_LO   10
`define SLTR_TX_MODEM_HI   13

// Receive register bit positions
`define SLTR_RX_RUN        0
`define SLTR_RX_CTL1       1
`define SLTR_RX_CTL3       3
`define SLTR_RX_CHARACTER_MATCH_IRQ_ENABLE    4
`define SLTR_RECEIVE_COMPLETE_IRQ_ENABLE    5
`define SLTR_RX_SDONE      6
`define SLTR_RX_PDONE      7
`define SLTR_RX_MATCH      15

// Reset values of held bits
`define SLTR_TX_RESET      6'h00
`define SLTR_RX_RESET      8'h00

`endif

// ### verilog/sltr_pkg.sv
package sltr_pkg;

  // Locally held transmit bits, msb first
  typedef struct packed {
    logic pdone;
    logic sdone;
    logic done_ie;
    logic error_irq_enable;
    logic ctl1;
    logic run;
  } sltr_tx_t;

  // Locally held receive bits, msb first
  typedef struct packed {
    logic match;
    logic pdone;
    logic sdone;
    logic done_ie;
    logic character_match_irq_enable;
    logic ctl3;
    logic ctl1;
    logic run;
  } sltr_rx_t;

  // Hardware events from the surrounding logic
  typedef struct packed {
    logic tx_s_ovf;
    logic tx_p_ovf;
    logic tx_cc_ovf;
    logic rx_s_ovf;
    logic rx_p_ovf;
    logic rx_cc_ovf;
    logic char_detect;
  } sltr_event_t;

endpackage : sltr_pkg

// ### verilog/sltr_rx_hold.sv
`timescale 1ns/1ps
`include "sltr_defs.svh"

module sltr_rx_hold (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic init_pulse,
  input  wire logic overflow,
  input  wire logic block_check_cycle,
  input  wire logic done_flag,
  output logic      set_done
);

  logic hold_r;
  logic done_prev_r;
  logic done_rise;

  assign done_rise = done_flag & ~done_prev_r;
  assign set_done  = hold_r & ~block_check_cycle;

  always_ff @(posedge sys_clk) begin
    if (reset || init_pulse) begin
      done_prev_r <= 1'b0;
    end else begin
      done_prev_r <= done_flag;
    end
  end

  // New overflow wins over the clearing edge
  always_ff @(posedge sys_clk) begin
    if (reset || init_pulse) begin
      hold_r <= 1'b0;
    end else if (overflow) begin
      hold_r <= 1'b1;
    end else if (done_rise) begin
      hold_r <= 1'b0;
    end
  end

endmodule : sltr_rx_hold

// ### verilog/sltr_csr.sv
`timescale 1ns/1ps
`include "sltr_defs.svh"

module sltr_csr (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 bus_init,
  input  wire logic                 master_clear,
  input  wire logic                 sel_tx,
  input  wire logic                 sel_rx,
  input  wire logic                 word_write,
  input  wire logic                 byte_write,
  input  wire logic                 byte_high,
  input  wire logic [15:0]          wdata,
  input  wire logic [7:0]           err_flags,
  input  wire sltr_pkg::sltr_event_t events,
  input  wire logic                 block_check_cycle,
  input  wire logic                 tx_active,
  input  wire logic [3:0]           modem_in,
  output logic [15:0]               tx_rdata,
  output logic [15:0]               rx_rdata,
  output sltr_pkg::sltr_tx_t        tx_bits,
  output sltr_pkg::sltr_rx_t        rx_bits,
  output logic                      init_pulse,
  output logic                      vector_a_request,
  output logic                      vector_b_request
);

  //----------------------------------------------------------------
  // Decode and error gathering
  //----------------------------------------------------------------
  sltr_pkg::sltr_tx_t tx_r;
  sltr_pkg::sltr_tx_t tx_nxt;
  sltr_pkg::sltr_rx_t rx_r;
  sltr_pkg::sltr_rx_t rx_nxt;
  logic               tx_load_lo;
  logic               rx_load_lo;
  logic               rx_load_hi;
  logic               tx_err;
  logic               rx_err;
  logic               error_summary;
  logic [1:0]         rx_ovf;
  logic [1:0]         rx_set_done;
  logic [1:0]         rx_done_now;
  logic [15:0]        tx_rdata_r;
  logic [15:0]        rx_rdata_r;

  assign init_pulse = bus_init | master_clear;

  assign tx_load_lo = sel_tx & (word_write | (byte_write & ~byte_high));
  assign rx_load_lo = sel_rx & (word_write | (byte_write & ~byte_high));
  assign rx_load_hi = sel_rx & (word_write | (byte_write & byte_high));

  assign tx_err        = err_flags[0] | err_flags[2] | err_flags[4];
  assign rx_err        = err_flags[1] | err_flags[3] | err_flags[5];
  assign error_summary = |err_flags;

  //----------------------------------------------------------------
  // Receive done holding latches
  //----------------------------------------------------------------
  assign rx_ovf      = {events.rx_p_ovf, events.rx_s_ovf};
  assign rx_done_now = {rx_r.pdone, rx_r.sdone};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_hold
      sltr_rx_hold u_hold (
        .sys_clk           (sys_clk),
        .reset             (reset),
        .init_pulse        (init_pulse),
        .overflow          (rx_ovf[i]),
        .block_check_cycle (block_check_cycle),
        .done_flag         (rx_done_now[i]),
        .set_done          (rx_set_done[i])
      );
    end
  endgenerate

  //----------------------------------------------------------------
  // Transmit register
  //----------------------------------------------------------------
  always_comb begin
    tx_nxt = tx_r;
    if (tx_load_lo) begin
      tx_nxt.run     = wdata[`SLTR_TX_RUN];
      tx_nxt.ctl1    = wdata[`SLTR_TX_CTL1];
      tx_nxt.error_irq_enable  = wdata[`SLTR_TX_ERROR_IRQ_ENABLE];
      tx_nxt.done_ie = wdata[`SLTR_TRANSMIT_COMPLETE_IRQ_ENABLE];
      tx_nxt.sdone   = tx_r.sdone & wdata[`SLTR_TX_SDONE];
      tx_nxt.pdone   = tx_r.pdone & wdata[`SLTR_TX_PDONE];
    end
    if (tx_err || events.tx_cc_ovf) begin
      tx_nxt.run = 1'b0;
    end
    if (events.tx_s_ovf) begin
      tx_nxt.sdone = 1'b1;
    end
    if (events.tx_p_ovf) begin
      tx_nxt.pdone = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || init_pulse) begin
      tx_r <= `SLTR_TX_RESET;
    end else begin
      tx_r <= tx_nxt;
    end
  end

  //----------------------------------------------------------------
  // Receive register
  //----------------------------------------------------------------
  always_comb begin
    rx_nxt = rx_r;
    if (rx_load_lo) begin
      rx_nxt.run     = wdata[`SLTR_RX_RUN];
      rx_nxt.ctl1    = wdata[`SLTR_RX_CTL1];
      rx_nxt.ctl3    = wdata[`SLTR_RX_CTL3];
      rx_nxt.character_match_irq_enable = wdata[`SLTR_RX_CHARACTER_MATCH_IRQ_ENABLE];
      rx_nxt.done_ie = wdata[`SLTR_RECEIVE_COMPLETE_IRQ_ENABLE];
      rx_nxt.sdone   = rx_r.sdone & wdata[`SLTR_RX_SDONE];
      rx_nxt.pdone   = rx_r.pdone & wdata[`SLTR_RX_PDONE];
    end
    if (rx_load_hi) begin
      rx_nxt.match = rx_r.match & wdata[`SLTR_RX_MATCH];
    end
    if (rx_err || events.rx_cc_ovf) begin
      rx_nxt.run = 1'b0;
    end
    if (events.char_detect) begin
      rx_nxt.match = 1'b1;
    end
    if (rx_set_done[0]) begin
      rx_nxt.sdone = 1'b1;
    end
    if (rx_set_done[1]) begin
      rx_nxt.pdone = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || init_pulse) begin
      rx_r <= `SLTR_RX_RESET;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  //----------------------------------------------------------------
  // Read-back images and outputs
  //----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_rdata_r <= 16'h0000;
    end else begin
      tx_rdata_r <= {2'b00, modem_in, 2'b00, tx_r.pdone, tx_r.sdone, tx_r.done_ie, 1'b0,
                     tx_r.error_irq_enable, 1'b0, tx_r.ctl1, tx_r.run};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_rdata_r <= 16'h0000;
    end else begin
      rx_rdata_r <= {rx_r.match, 7'h00, rx_r.pdone, rx_r.sdone, rx_r.done_ie, rx_r.character_match_irq_enable,
                     rx_r.ctl3, 1'b0, rx_r.ctl1, rx_r.run};
    end
  end

  assign tx_rdata = tx_rdata_r;
  assign rx_rdata = rx_rdata_r;
  assign tx_bits  = tx_r;
  assign rx_bits  = rx_r;

  // Transmit done interrupts are held off while the transmit run bit is dropped mid-transfer
  assign vector_b_request = (error_summary & tx_r.error_irq_enable)
                          | (tx_r.done_ie & (tx_r.sdone | tx_r.pdone)
                             & ~(~tx_r.run & tx_active));

  assign vector_a_request = (rx_r.match & rx_r.character_match_irq_enable)
                          | (rx_r.done_ie & (rx_r.sdone | rx_r.pdone));

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_tx_low_load: assert property (
    (tx_load_lo && !init_pulse && !tx_err && !events.tx_cc_ovf)
      |=> (tx_r.run == $past(wdata[0])) && (tx_r.done_ie == $past(wdata[5])))
    else $error("transmit low-byte write not loaded");

  a_tx_init_clear: assert property (
    init_pulse |=> (tx_r == 6'h00))
    else $error("transmit bits not cleared by init");

  a_tx_run_stop: assert property (
    (tx_err || events.tx_cc_ovf) |=> !tx_r.run)
    else $error("transmit run not cleared on error or overflow");

  a_tx_flag_nosw: assert property (
    (tx_load_lo && !tx_r.sdone && !events.tx_s_ovf && !init_pulse) |=> !tx_r.sdone)
    else $error("software set a transmit done flag");

  a_tx_sdone_set: assert property (
    (events.tx_s_ovf && !init_pulse) |=> tx_r.sdone)
    else $error("secondary overflow did not set done");

  a_tx_pdone_set: assert property (
    (events.tx_p_ovf && !init_pulse) |=> tx_r.pdone)
    else $error("primary overflow did not set done");

  a_vecb_error: assert property (
    (error_summary && tx_r.error_irq_enable) |-> vector_b_request)
    else $error("error interrupt request missing");

  a_vecb_suppress: assert property (
    (!tx_r.run && tx_active && !(error_summary && tx_r.error_irq_enable)) |-> !vector_b_request)
    else $error("done request not suppressed while stopped and active");

  a_rx_high_load: assert property (
    (rx_load_hi && !events.char_detect && !init_pulse)
      |=> rx_r.match == ($past(rx_r.match) && $past(wdata[15])))
    else $error("receive high-byte write wrong");

  a_rx_init_clear: assert property (
    init_pulse |=> (rx_r == 8'h00))
    else $error("receive bits not cleared by init");

  a_rx_run_stop: assert property (
    (rx_err || events.rx_cc_ovf) |=> !rx_r.run)
    else $error("receive run not cleared on error or overflow");

  a_match_set: assert property (
    (events.char_detect && !init_pulse) |=> rx_r.match)
    else $error("character detect did not set match flag");

  a_rx_defer_bcc: assert property (
    (block_check_cycle && !rx_r.pdone) |=> !rx_r.pdone)
    else $error("receive done set during block check");

  a_rx_hold_done: assert property (
    (events.rx_p_ovf && !init_pulse) ##1 (!block_check_cycle && !init_pulse) |=> rx_r.pdone)
    else $error("held overflow did not set done");

  a_veca_req: assert property (
    ((rx_r.match && rx_r.character_match_irq_enable) || (rx_r.done_ie && (rx_r.sdone || rx_r.pdone)))
      |-> vector_a_request)
    else $error("vector A request missing");

  a_modem_read: assert property (
    !reset |=> (tx_rdata[13:10] == $past(modem_in)) && !tx_rdata[14])
    else $error("modem bits not reflected");

  a_err_summary: assert property (
    (err_flags[7] && tx_r.error_irq_enable) |-> vector_b_request)
    else $error("single error flag did not raise summary");

  a_set_wins: assert property (
    (events.tx_s_ovf && tx_load_lo && !wdata[6] && !init_pulse) |=> tx_r.sdone)
    else $error("software clear beat hardware set");

  a_init_comb: assert property (
    (bus_init || master_clear) |-> init_pulse)
    else $error("init pulse missing");

  a_tx_pdone_nosw: assert property (
    (tx_load_lo && !tx_r.pdone && !events.tx_p_ovf && !init_pulse) |=> !tx_r.pdone)
    else $error("software set transmit primary done");

  a_vecb_done: assert property (
    (tx_r.done_ie && (tx_r.sdone || tx_r.pdone) && (tx_r.run || !tx_active))
      |-> vector_b_request)
    else $error("transmit done request missing");

  a_rx_low_load: assert property (
    (rx_load_lo && !init_pulse && !rx_err && !events.rx_cc_ovf)
      |=> (rx_r.run == $past(wdata[0])) && (rx_r.character_match_irq_enable == $past(wdata[4])))
    else $error("receive low-byte write not loaded");

  a_rx_flag_nosw: assert property (
    (rx_load_lo && !rx_r.pdone && !rx_set_done[1] && !init_pulse) |=> !rx_r.pdone)
    else $error("software set a receive done flag");

  a_rx_sdone_hold: assert property (
    (events.rx_s_ovf && !init_pulse) ##1 (!block_check_cycle && !init_pulse) |=> rx_r.sdone)
    else $error("held secondary overflow did not set done");

  a_veca_quiet: assert property (
    (!(rx_r.match && rx_r.character_match_irq_enable) && !(rx_r.done_ie && (rx_r.sdone || rx_r.pdone)))
      |-> !vector_a_request)
    else $error("spurious vector A request");

  a_tx_err_map: assert property (
    (err_flags[0] || err_flags[2] || err_flags[4]) |=> !tx_r.run)
    else $error("transmit error flag did not stop transmit run");

  a_rx_err_map: assert property (
    (err_flags[1] || err_flags[3] || err_flags[5]) |=> !rx_r.run)
    else $error("receive error flag did not stop receive run");

  a_rx_match_wins: assert property (
    (events.char_detect && rx_load_hi && !wdata[15] && !init_pulse) |=> rx_r.match)
    else $error("software clear beat character match");

  c_tx_done_irq: cover property (tx_r.pdone && tx_r.done_ie && vector_b_request);
  c_rx_deferred: cover property (events.rx_p_ovf ##1 block_check_cycle [*2] ##[1:8] rx_r.pdone);
  c_match_irq:   cover property (events.char_detect ##1 vector_a_request);
  c_err_stop:    cover property (tx_r.run ##1 tx_err ##1 !tx_r.run);

endmodule : sltr_csr

// ### testbench/sltr_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host processor model: register writes on the parallel bus
// ------------------------------------------------------------
module sltr_host (
  input  wire logic        sys_clk,
  output logic             sel_tx,
  output logic             sel_rx,
  output logic             word_write,
  output logic             byte_write,
  output logic             byte_high,
  output logic [15:0]      wdata
);
  initial begin
    sel_tx     = 1'b0;
    sel_rx     = 1'b0;
    word_write = 1'b0;
    byte_write = 1'b0;
    byte_high  = 1'b0;
    wdata      = 16'h0000;
  end

  // Kind k: 0 word, 1 low byte, 2 high byte; flags are cleared by writing 0
  task automatic wr(input logic tx, input logic [1:0] k, input logic [15:0] d);
    @(posedge sys_clk);
    sel_tx     <= tx;
    sel_rx     <= !tx;
    word_write <= (k == 2'h0);
    byte_write <= (k != 2'h0);
    byte_high  <= (k == 2'h2);
    wdata      <= d;
    @(posedge sys_clk);
    sel_tx     <= 1'b0;
    sel_rx     <= 1'b0;
    word_write <= 1'b0;
    byte_write <= 1'b0;
    byte_high  <= 1'b0;
    // Released data lines no longer show the last value
    wdata      <= ~d;
  endtask : wr
endmodule : sltr_host

// ### testbench/sltr_csr_test.sv
`timescale 1ns/1ps
module sltr_csr_test;
  logic                  sys_clk, reset, bus_init, master_clear;
  logic                  block_check_cycle, tx_active, init_pulse;
  logic                  vector_a_request, vector_b_request;
  logic                  sel_tx, sel_rx, word_write, byte_write, byte_high;
  logic [15:0]           wdata, tx_rdata, rx_rdata;
  logic [7:0]            err_flags;
  logic [3:0]            modem_in;
  sltr_pkg::sltr_event_t events;
  sltr_pkg::sltr_tx_t    tx_bits;
  sltr_pkg::sltr_rx_t    rx_bits;
  int                    n_fail, n_checks, n_cyc;

  // ----------------------------------------------------------
  // Instances
  // ----------------------------------------------------------
  sltr_host sltr_host_i (.sys_clk(sys_clk), .sel_tx(sel_tx), .sel_rx(sel_rx),
    .word_write(word_write), .byte_write(byte_write), .byte_high(byte_high),
    .wdata(wdata));
  sltr_csr sltr_csr_i (.sys_clk(sys_clk), .reset(reset), .bus_init(bus_init),
    .master_clear(master_clear), .sel_tx(sel_tx), .sel_rx(sel_rx),
    .word_write(word_write), .byte_write(byte_write), .byte_high(byte_high),
    .wdata(wdata), .err_flags(err_flags), .events(events),
    .block_check_cycle(block_check_cycle), .tx_active(tx_active),
    .modem_in(modem_in), .tx_rdata(tx_rdata), .rx_rdata(rx_rdata),
    .tx_bits(tx_bits), .rx_bits(rx_bits), .init_pulse(init_pulse),
    .vector_a_request(vector_a_request), .vector_b_request(vector_b_request));

  // ----------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    n_cyc++;
    if (n_cyc == 2000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ev(input sltr_pkg::sltr_event_t e);
    @(posedge sys_clk);
    events <= e;
    @(posedge sys_clk);
    events <= '0;
  endtask : ev

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cyc

  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_tx;
    sltr_host_i.wr(1'b1, 2'h0, 16'hffff);
    cyc(0);
    chk({10'h000, tx_bits}, 16'h000f);
    cyc(1);
    chk(tx_rdata, 16'h142b);
    sltr_host_i.wr(1'b1, 2'h2, 16'h0000);
    cyc(0);
    chk({10'h000, tx_bits}, 16'h000f);
    ev(7'h60);
    cyc(2);
    chk({10'h000, tx_bits}, 16'h003f);
    chk({15'h0000, vector_b_request}, 16'h0001);
    @(posedge sys_clk);
    tx_active <= 1'b1;
    ev(7'h10);
    cyc(2);
    chk({10'h000, tx_bits}, 16'h003e);
    chk({15'h0000, vector_b_request}, 16'h0000);
    @(posedge sys_clk);
    err_flags <= 8'h80;
    cyc(1);
    chk({15'h0000, vector_b_request}, 16'h0001);
    @(posedge sys_clk);
    err_flags <= 8'h00;
    tx_active <= 1'b0;
    sltr_host_i.wr(1'b1, 2'h1, 16'h0001);
    cyc(0);
    chk({10'h000, tx_bits}, 16'h0001);
    @(posedge sys_clk);
    err_flags <= 8'h10;
    cyc(2);
    chk({10'h000, tx_bits}, 16'h0000);
    @(posedge sys_clk);
    err_flags <= 8'h00;
    fork
      sltr_host_i.wr(1'b1, 2'h0, 16'h0000);
      ev(7'h60);
    join
    cyc(2);
    chk({10'h000, tx_bits}, 16'h0030);
  endtask : t_tx

  task automatic t_rx;
    sltr_host_i.wr(1'b0, 2'h0, 16'hffff);
    cyc(0);
    chk({8'h00, rx_bits}, 16'h001f);
    cyc(1);
    chk(rx_rdata, 16'h003b);
    ev(7'h01);
    cyc(2);
    chk({8'h00, rx_bits}, 16'h009f);
    chk({15'h0000, vector_a_request}, 16'h0001);
    sltr_host_i.wr(1'b0, 2'h2, 16'h0000);
    sltr_host_i.wr(1'b0, 2'h1, 16'h0021);
    cyc(0);
    chk({8'h00, rx_bits}, 16'h0011);
    @(posedge sys_clk);
    block_check_cycle <= 1'b1;
    ev(7'h04);
    cyc(4);
    chk({8'h00, rx_bits}, 16'h0011);
    @(posedge sys_clk);
    block_check_cycle <= 1'b0;
    cyc(4);
    chk({8'h00, rx_bits}, 16'h0051);
    chk({15'h0000, vector_a_request}, 16'h0001);
    sltr_host_i.wr(1'b0, 2'h1, 16'h0001);
    cyc(4);
    chk({8'h00, rx_bits}, 16'h0001);
    @(posedge sys_clk);
    err_flags <= 8'h02;
    cyc(2);
    chk({8'h00, rx_bits}, 16'h0000);
    @(posedge sys_clk);
    err_flags <= 8'h00;
    sltr_host_i.wr(1'b0, 2'h1, 16'h0001);
    ev(7'h02);
    cyc(2);
    chk({8'h00, rx_bits}, 16'h0000);
    ev(7'h0c);
    cyc(2);
    chk({8'h00, rx_bits}, 16'h0060);
    fork
      sltr_host_i.wr(1'b0, 2'h2, 16'h0000);
      ev(7'h01);
    join
    cyc(0);
    chk({8'h00, rx_bits}, 16'h00e0);
  endtask : t_rx

  task automatic t_init;
    for (int i = 0; i < 2; i++) begin
      sltr_host_i.wr(1'b1, 2'h0, 16'hffff);
      sltr_host_i.wr(1'b0, 2'h0, 16'hffff);
      @(posedge sys_clk);
      bus_init     <= (i == 0);
      master_clear <= (i == 1);
      cyc(0);
      chk({15'h0000, init_pulse}, 16'h0001);
      @(posedge sys_clk);
      bus_init     <= 1'b0;
      master_clear <= 1'b0;
      cyc(0);
      chk({10'h000, tx_bits}, 16'h0000);
      chk({8'h00, rx_bits}, 16'h0000);
    end
    @(posedge sys_clk);
    modem_in <= 4'ha;
    cyc(1);
    chk(tx_rdata, 16'h2800);
  endtask : t_init

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    bus_init = 1'b0;
    master_clear = 1'b0;
    block_check_cycle = 1'b0;
    tx_active = 1'b0;
    err_flags = 8'h00;
    modem_in = 4'h5;
    events = '0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    cyc(0);
    chk({10'h000, tx_bits}, 16'h0000);
    chk({8'h00, rx_bits}, 16'h0000);
    t_tx();
    t_rx();
    t_init();
    end_sim();
  end
endmodule : sltr_csr_test
